// File: pss_sram_port.sv
// Pipelined synchronous SRAM port: command decode, burst, array, data lanes
//
// Contract
// - Load/step low loads external address; high uses next burst address.
// - Clock edge captures address, data and controls; not oe or strap.
// - Clock enable inactive holds all state including pending operations.
// - Data moves on two bidirectional byte lanes, each with its enable.
// - Two low address bits preset the burst counter on load.
// - Byte enables ignored in reads; writes touch only enabled lanes.
// - Selected only when pick a and pick b low, pick hi high.
// - Selected, write low, load low: load address, new write.
// - Selected, write high, load low: load address, new read.
// - Not selected with load low deselects; step keeps it deselected.
// - Step continues previous write or read at next counter address.
// - Step cycles ignore chip picks and write command.
// - Byte enables used on new writes and burst writes only.
// - Write with no enables still loads address or steps counter.
// - Enabled lanes written, others kept; write high on a selected load reads.
// - Linear mode steps low bits upward modulo four.
// - Interleaved mode xors start bits with beat index.
`default_nettype none
module pss_sram_port
   import pss_pkg::*;
(
   // Clock and reset
   input  wire logic               CORE_CLK_I,
   input  wire logic               RESETN_I,
   // Command pins
   input  wire logic               CLK_EN_N_I,
   input  wire logic               CHIP_PICK_A_N_I,
   input  wire logic               CHIP_PICK_HI_I,
   input  wire logic               CHIP_PICK_B_N_I,
   input  wire logic               WRITE_CMD_N_I,
   input  wire logic [LANES-1:0]   BYTE_WRITE_EN_N_I,
   input  wire logic               LOAD_OR_STEP_I,
   input  wire logic [ADDR_W-1:0]  ADDR_IN_I,
   // Static and asynchronous pins
   input  wire logic               BURST_ORDER_STRAP_I,
   input  wire logic               OUT_EN_N_I,
   // Byte lanes
   input  wire logic [DATA_W-1:0]  BYTE_LANE_IO_I,
   output logic      [DATA_W-1:0]  BYTE_LANE_IO_O,
   output logic      [LANES-1:0]   BYTE_LANE_IO_OE_O
);
   // ------------------------------------------------------------
   // Input capture
   // ------------------------------------------------------------
   logic               en;
   logic               selected;
   logic               new_cmd;
   logic               load;
   logic               step;
   logic               interleave;
   logic [ADDR_W-1:0]  burst_addr;
   pss_op_type         op_q;
   pss_op_type         op_d;
   pss_acc_type        acc_q;
   pss_acc_type        acc_d;
   pss_acc_type        wr_q;
   logic [DATA_W-1:0]  rd_d;
   logic [DATA_W-1:0]  rd_q;
   logic               rd_valid_q;
   logic [LANES-1:0]   fwd;

   assign en         = !CLK_EN_N_I;
   assign selected   = !CHIP_PICK_A_N_I && CHIP_PICK_HI_I && !CHIP_PICK_B_N_I;
   assign new_cmd    = !LOAD_OR_STEP_I;
   assign interleave = BURST_ORDER_STRAP_I != STRAP_LINEAR;

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   always_comb begin
      op_d = op_q;
      if (new_cmd) begin
         if (!selected) begin
            op_d = OP_DESEL;
         end else if (!WRITE_CMD_N_I) begin
            op_d = OP_WRITE;
         end else begin
            op_d = OP_READ;
         end
      end
      // Step keeps op_q; picks and write command unused here
   end

   assign load = new_cmd && selected;
   assign step = !new_cmd && op_q != OP_DESEL;

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         op_q <= OP_DESEL;
      end else if (en) begin
         op_q <= op_d;
      end
   end

   // ------------------------------------------------------------
   // Burst counter
   // ------------------------------------------------------------
   pss_burst_addr u_burst (
      .clk_i        (CORE_CLK_I),
      .rst_n_i      (RESETN_I),
      .en_i         (en),
      .load_i       (load),
      .step_i       (step),
      .interleave_i (interleave),
      .addr_i       (ADDR_IN_I),
      .addr_o       (burst_addr)
   );

   // ------------------------------------------------------------
   // Access stage
   // ------------------------------------------------------------
   always_comb begin
      acc_d       = '0;
      acc_d.valid = op_d != OP_DESEL;
      acc_d.wr    = op_d == OP_WRITE;
      acc_d.addr  = new_cmd ? ADDR_IN_I : burst_addr;
      acc_d.be_n  = (op_d == OP_WRITE) ? BYTE_WRITE_EN_N_I : BE_NONE_N;
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         acc_q <= '0;
      end else if (en) begin
         acc_q <= acc_d;
      end
   end

   // Write stage one edge behind, so write data matches read latency
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wr_q <= '0;
      end else if (en) begin
         wr_q <= acc_q;
      end
   end

   // ------------------------------------------------------------
   // Array and byte lanes
   // ------------------------------------------------------------
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] mem [DEPTH];

      always_ff @(posedge CORE_CLK_I) begin
         if (en && wr_q.valid && wr_q.wr && !wr_q.be_n[g]) begin
            mem[wr_q.addr] <= BYTE_LANE_IO_I[g*LANE_W +: LANE_W];
         end
      end
      // Read of a lane written on the same edge takes the lane data
      assign fwd[g]                   = wr_q.valid && wr_q.wr && !wr_q.be_n[g] && wr_q.addr == acc_q.addr;
      assign rd_d[g*LANE_W +: LANE_W] = fwd[g] ? BYTE_LANE_IO_I[g*LANE_W +: LANE_W] : mem[acc_q.addr];
      assign BYTE_LANE_IO_OE_O[g] = rd_valid_q && !OUT_EN_N_I;
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rd_q       <= '0;
         rd_valid_q <= 1'b0;
      end else if (en) begin
         rd_valid_q <= acc_q.valid && !acc_q.wr;
         if (acc_q.valid && !acc_q.wr) begin
            rd_q <= rd_d;
         end
      end
   end

   assign BYTE_LANE_IO_O = rd_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_hold;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      CLK_EN_N_I |=> $stable(acc_q) && $stable(op_q) && $stable(wr_q) && $stable(rd_q) && $stable(rd_valid_q);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved while clock disabled");

   property p_new_write;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && new_cmd && selected && !WRITE_CMD_N_I) |=> acc_q.valid && acc_q.wr && acc_q.addr == $past(ADDR_IN_I);
   endproperty
   a_new_write: assert property (p_new_write) else $error("new write not loaded");

   property p_new_read;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && new_cmd && selected && WRITE_CMD_N_I) |=> acc_q.valid && !acc_q.wr && acc_q.be_n == BE_NONE_N;
   endproperty
   a_new_read: assert property (p_new_read) else $error("new read not loaded");

   property p_desel;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && new_cmd && !selected) ##1 (en && !new_cmd) |=> !acc_q.valid;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect not kept");

   property p_read_out;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && acc_q.valid && !acc_q.wr) |=> rd_valid_q;
   endproperty
   a_read_out: assert property (p_read_out) else $error("read data not registered");

   property p_step_keeps;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && !new_cmd && op_q == OP_WRITE) |=> acc_q.wr && acc_q.be_n == $past(BYTE_WRITE_EN_N_I);
   endproperty
   a_step_keeps: assert property (p_step_keeps) else $error("burst write lost");

   property p_oe;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      OUT_EN_N_I |-> BYTE_LANE_IO_OE_O == '0;
   endproperty
   a_oe: assert property (p_oe) else $error("lanes driven with output disabled");

   property p_lsb;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && load) |=> acc_q.addr[BURST_W-1:0] == $past(ADDR_IN_I[BURST_W-1:0]);
   endproperty
   a_lsb: assert property (p_lsb) else $error("start bits not loaded");

   property p_wr_stage;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && acc_q.valid && acc_q.wr) |=> wr_q.valid && wr_q.wr && wr_q.addr == $past(acc_q.addr);
   endproperty
   a_wr_stage: assert property (p_wr_stage) else $error("write stage lost");

   property p_burst_upper;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (en && step) |=> acc_q.addr[ADDR_W-1:BURST_W] == $past(acc_q.addr[ADDR_W-1:BURST_W]);
   endproperty
   a_burst_upper: assert property (p_burst_upper) else $error("burst left its block");
endmodule : pss_sram_port
`default_nettype wire

// File: pss_pkg.sv
// Package for the pipelined synchronous SRAM port: widths, layouts, states
`default_nettype none
package pss_pkg;
   // ------------------------------------------------------------
   // Organisation
   // ------------------------------------------------------------
   localparam int ADDR_W      = 18;
   localparam int LANE_W      = 9;
   localparam int LANES       = 2;
   localparam int DATA_W      = LANE_W * LANES;
   localparam int DEPTH       = 1 << ADDR_W;
   localparam int BURST_W     = 2;
   localparam int BURST_LSB   = 0;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
   localparam logic [LANES-1:0]   BE_NONE_N = 2'h3;
   localparam logic               STRAP_LINEAR = 1'h0;

   // ------------------------------------------------------------
   // Operation kinds
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_DESEL,
      OP_READ,
      OP_WRITE
   } pss_op_type;

   // Pending array access, one stage behind the command
   typedef struct packed {
      logic                   valid;
      logic                   wr;
      logic [ADDR_W-1:0]      addr;
      logic [LANES-1:0]       be_n;
   } pss_acc_type;
endpackage : pss_pkg
`default_nettype wire

// File: pss_burst_addr.sv
// Burst address sequencer: loads start bits and steps linear or interleaved
`default_nettype none
module pss_burst_addr
   import pss_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               en_i,
   // Control
   input  wire logic               load_i,
   input  wire logic               step_i,
   input  wire logic               interleave_i,
   input  wire logic [ADDR_W-1:0]  addr_i,
   // Address of the next burst beat
   output logic      [ADDR_W-1:0]  addr_o
);
   logic [ADDR_W-1:0]   base_q;
   logic [BURST_W-1:0]  beat_q;
   logic [BURST_W-1:0]  next_beat;
   logic [BURST_W-1:0]  low_bits;

   assign next_beat = beat_q + BURST_ONE;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         base_q <= '0;
         beat_q <= '0;
      end else if (en_i) begin
         if (load_i) begin
            base_q <= addr_i;
            beat_q <= '0;
         end else if (step_i) begin
            beat_q <= next_beat;
         end
      end
   end

   // Next beat: linear adds the beat index, interleaved xors it
   always_comb begin
      if (interleave_i) begin
         low_bits = base_q[BURST_LSB +: BURST_W] ^ next_beat;
      end else begin
         low_bits = base_q[BURST_LSB +: BURST_W] + next_beat;
      end
   end

   assign addr_o = {base_q[ADDR_W-1:BURST_W], low_bits};
endmodule : pss_burst_addr
`default_nettype wire

// File: pss_ctrl_model.sv
// Controller side of the byte lanes: drives write data and resolves the wire
`default_nettype none
module pss_ctrl_model
   import pss_pkg::*;
(
   // Clock
   input  wire logic              clk_i,
   // Bench control
   input  wire logic              drv_i,
   input  wire logic [DATA_W-1:0] dat_i,
   // Device lanes
   input  wire logic [DATA_W-1:0] dev_dat_i,
   input  wire logic [LANES-1:0]  dev_oe_i,
   output logic      [DATA_W-1:0] lane_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] last_q;

   // -------------------------------------------------------------
   // Wire level per lane; released lanes show the inverse
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      last_q <= lane_o;
   end
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         lane_o[i*LANE_W +: LANE_W] = dev_oe_i[i] ? dev_dat_i[i*LANE_W +: LANE_W] :
            drv_i ? dat_i[i*LANE_W +: LANE_W] : ~last_q[i*LANE_W +: LANE_W];
      end
   end
endmodule : pss_ctrl_model
`default_nettype wire

// File: pss_sram_port_test.sv
// Self-checking bench for the pipelined synchronous SRAM port
`default_nettype none
module pss_sram_port_test
   import pss_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk = 0, rstn = 0, cke_n = 1, pa_n = 1, phi = 0, pb_n = 1;
   logic              wr_n = 1, ld = 0, strap = 0, oe_n = 0, drv = 0;
   logic              w1v = 0, w2v = 0, rpv = 0, rv = 0;
   logic [LANES-1:0]  be_n = BE_NONE_N, doe, w1be, w2be;
   logic [ADDR_W-1:0] addr = '0, base, w1a, w2a, rpa;
   logic [DATA_W-1:0] dat = '0, lane, dout, gen = '0, w1d = '0, w2d = '0, rq;
   logic [DATA_W-1:0] mem [int];
   logic [1:0]        kind = 2'h0, k;
   int                err_count = 0, total_checks = 0;

   always #2 clk = ~clk;

   pss_sram_port u_dut (.CORE_CLK_I(clk), .RESETN_I(rstn), .CLK_EN_N_I(cke_n), .CHIP_PICK_A_N_I(pa_n),
      .CHIP_PICK_HI_I(phi), .CHIP_PICK_B_N_I(pb_n), .WRITE_CMD_N_I(wr_n), .BYTE_WRITE_EN_N_I(be_n),
      .LOAD_OR_STEP_I(ld), .ADDR_IN_I(addr), .BURST_ORDER_STRAP_I(strap), .OUT_EN_N_I(oe_n),
      .BYTE_LANE_IO_I(lane), .BYTE_LANE_IO_O(dout), .BYTE_LANE_IO_OE_O(doe));
   pss_ctrl_model u_ctrl (.clk_i(clk), .drv_i(drv), .dat_i(dat), .dev_dat_i(dout), .dev_oe_i(doe),
      .lane_o(lane));

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic cyc(input logic ce_n, input logic [2:0] pk, input logic w_n, input logic stp,
                      input logic [1:0] be, input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] ad;
      {cke_n, pa_n, phi, pb_n, wr_n, ld, be_n, addr, drv, dat} = {ce_n, pk, w_n, stp, be, a, w2v, w2d};
      @(posedge clk);
      #1;
      if (!ce_n) begin
         // Write data lands two enabled edges after its command
         for (int i = 0; i < LANES; i++)
            if (w2v && !w2be[i]) mem[w2a][i*LANE_W +: LANE_W] = w2d[i*LANE_W +: LANE_W];
         {w2v, w2a, w2be, w2d} = {w1v, w1a, w1be, w1d};
         w1v = 0;
         // Read of the previous command sees the write that just landed
         rv = rpv;
         if (rpv) rq = mem.exists(rpa) ? mem[rpa] : gen;
         if (!stp) begin
            kind = (pk != 3'h2) ? 2'h0 : (w_n ? 2'h1 : 2'h2);
            base = a;
            k = 2'h0;
         end else begin
            k = k + 2'h1;
         end
         ad = {base[ADDR_W-1:2], strap ? base[1:0] ^ k : base[1:0] + k};
         {rpv, rpa} = {kind == 2'h1, ad};
         if (kind == 2'h2) begin
            {w1v, w1a, w1be} = {1'b1, ad, be};
            w1d = {ad[8:0], ad[8:0]} ^ gen;
         end
      end
      chk("lane_oe", DATA_W'({2{rv & !oe_n}}), DATA_W'(doe));
      if (rv && !oe_n) chk("lane_data", rq, dout);
   endtask : cyc

   task automatic flush;
      repeat (3) cyc(0, 3'h7, 1, 0, 2'h3, '0);
   endtask : flush

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_linear;
      strap = 0;
      cyc(0, 3'h2, 0, 0, 2'h0, 18'h00101);
      repeat (3) cyc(0, 3'h5, 1, 1, 2'h0, 18'h3FFFF);
      gen = 18'h3FFFF;
      cyc(0, 3'h2, 0, 0, 2'h2, 18'h00102);
      cyc(0, 3'h2, 0, 0, 2'h3, 18'h00103);
      cyc(0, 3'h7, 1, 1, 2'h1, 18'h00000);
      cyc(0, 3'h2, 1, 0, 2'h0, 18'h00102);
      repeat (3) cyc(0, 3'h0, 0, 1, 2'h0, 18'h0);
      flush;
      $display("test linear done");
   endtask : t_linear

   task automatic t_interleave;
      strap = 1;
      gen = 18'h1555A;
      cyc(0, 3'h2, 0, 0, 2'h0, 18'h00202);
      repeat (3) cyc(0, 3'h7, 1, 1, 2'h0, 18'h0);
      cyc(0, 3'h2, 1, 0, 2'h0, 18'h00203);
      repeat (3) cyc(0, 3'h7, 0, 1, 2'h0, 18'h0);
      flush;
      $display("test interleave done");
   endtask : t_interleave

   task automatic t_select;
      logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
      strap = 0;
      foreach (bad[i]) cyc(0, bad[i], 1, 0, 2'h3, 18'h00101);
      cyc(0, 3'h2, 1, 1, 2'h3, 18'h00101);
      cyc(0, 3'h2, 1, 0, 2'h3, 18'h00100);
      cyc(0, 3'h7, 0, 1, 2'h0, 18'h0);
      flush;
      $display("test select done");
   endtask : t_select

   task automatic t_hold;
      cyc(0, 3'h2, 0, 0, 2'h0, 18'h00300);
      cyc(1, 3'h2, 1, 0, 2'h0, 18'h00200);
      cyc(0, 3'h2, 1, 0, 2'h0, 18'h00300);
      cyc(0, 3'h7, 1, 0, 2'h3, 18'h0);
      repeat (2) cyc(1, 3'h2, 0, 0, 2'h0, 18'h00301);
      oe_n = 1;
      cyc(1, 3'h2, 1, 0, 2'h0, 18'h0);
      oe_n = 0;
      flush;
      $display("test hold done");
   endtask : t_hold

   // -------------------------------------------------------------
   // Run control
   // -------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (2) @(posedge clk);
      #1;
      rstn = 1;
      t_linear();
      t_interleave();
      t_select();
      t_hold();
      close_out();
   end

   initial begin
      #20000;
      err_count++;
      close_out();
   end
endmodule : pss_sram_port_test
`default_nettype wire
